// *** rtl/boot_fe_pkg.sv ***
// constants, types and state layout of the serial boot front end
// assumes one 20 MHz clock and an Avalon-MM master for software
// Notes on behaviour
// - system clock 16 MHz from internal oscillator
// - first 2 Kbytes of RAM kept for boot
// - frames are 8 data, even parity, one stop
// - watchdog prescaler at maximum, refreshed periodically
// - tick timer measures host bit rate
// - poll both ports until one is selected
// - sync byte 0x7F starts autobaud, then commands
// - other port disabled once one is selected
// - jump returns used settings to reset values
// - flash written by half pages, unaligned starts
// - write address and count multiples of 4
// - data memory 0x08080000-0x08080FFF readable, writable
// - data memory erased by writes, never by erase
// - option bytes at 0x1FF80000, levels 0 to 2
// - read protect sets level 1
// - read unprotect sets level 0
// - no whole-memory erase command
// - level 1 then level 0 erases flash
// - regulator range 2 in boot mode
// - only the listed command codes accepted
// - rejections answered with byte 0x1F
`default_nettype none
package boot_fe_pkg;
   localparam int unsigned CLK_HZ     = 20_000_000;
   localparam int unsigned REFRESH_US = 1000;
   localparam logic [7:0]  SYS_CLK_MHZ   = 8'h10;
   localparam logic [1:0]  VREG_RANGE    = 2'h2;
   localparam logic [2:0]  WDT_PRESC_MAX = 3'h7;
   localparam logic [1:0]  STRAP_WAIT    = 2'h3;
   localparam logic [7:0]  SYNC_BYTE     = 8'h7F;
   localparam logic [7:0]  NACK_BYTE     = 8'h1F;
   localparam logic [3:0]  RX_LAST_BIT   = 4'h9;
   localparam logic [3:0]  TX_FRAME_BITS = 4'hB;
   localparam logic [31:0] FLASH_BASE = 32'h0800_0000;
   localparam logic [31:0] FLASH_LAST = 32'h0801_FFFF;
   localparam logic [31:0] DMEM_BASE  = 32'h0808_0000;
   localparam logic [31:0] DMEM_LAST  = 32'h0808_0FFF;
   localparam logic [31:0] SRAM_BASE  = 32'h2000_0000;
   localparam logic [31:0] SRAM_USER  = 32'h2000_0800;
   localparam logic [31:0] SRAM_LAST  = 32'h2000_3FFF;
   localparam logic [31:0] OPT_BASE   = 32'h1FF8_0000;
   localparam logic [31:0] OPT_LAST   = 32'h1FF8_001F;
   localparam logic [31:0] SYS_BASE   = 32'h1FF0_0000;
   localparam logic [31:0] SYS_LAST   = 32'h1FF0_0FFF;
   localparam logic [31:0] ALIGN_MASK = 32'h0000_0003;
   localparam logic [31:0] HALF_PAGE_MASK = 32'hFFFF_FF80;
   localparam logic [31:0] ERASE_ALL  = 32'hFFFF_FFFF;
   localparam logic [5:0]  REG_CTRL   = 6'h00;
   localparam logic [5:0]  REG_STATUS = 6'h04;
   localparam logic [5:0]  REG_BAUD   = 6'h08;
   localparam logic [5:0]  REG_CMD    = 6'h0C;
   localparam logic [5:0]  REG_RXD    = 6'h10;
   localparam logic [5:0]  REG_TXD    = 6'h14;
   localparam logic [5:0]  REG_ADDR   = 6'h18;
   localparam logic [5:0]  REG_COUNT  = 6'h1C;
   localparam logic [5:0]  REG_HPAGE  = 6'h20;
   localparam logic [1:0]  KIND_WRITE = 2'h0;
   localparam logic [1:0]  KIND_ERASE = 2'h1;
   localparam logic [1:0]  KIND_READ  = 2'h2;
   localparam logic [1:0]  PORT_NONE  = 2'h0;
   localparam logic [1:0]  LEVEL_0    = 2'h0;
   localparam logic [1:0]  LEVEL_1    = 2'h1;
   localparam logic [1:0]  LEVEL_2    = 2'h2;

   typedef enum logic [2:0] {S_STRAP, S_OFF, S_DETECT, S_CMD, S_DONE} top_state_t;
   typedef enum logic [1:0] {RX_OFF, RX_IDLE, RX_MEAS, RX_BITS} rx_phase_t;

   typedef struct packed {
      rx_phase_t   phase;
      logic [2:0]  sync;
      logic        level;
      logic [15:0] cnt;
      logic [15:0] per;
      logic [3:0]  bitn;
      logic [9:0]  shift;
      logic        got;
   } rx_t;

   typedef struct packed {
      logic [24:0] rsvd;
      logic [1:0]  kind;
      logic        check;
      logic        cmd_done;
      logic        unprot;
      logic        prot;
      logic        go;
   } ctrl_t;

   typedef struct packed {
      logic [18:0] rsvd;
      logic        boot_active;
      logic        dmem_write;
      logic        check_ok;
      logic        tx_busy;
      logic        rx_avail;
      logic        cmd_pend;
      logic [1:0]  prot;
      logic [2:0]  st;
      logic [1:0]  port;
   } status_t;

   typedef struct packed {
      top_state_t  st;
      logic [2:0]  sp;
      logic [2:0]  ss;
      logic [1:0]  wait_n;
      rx_t [1:0]   rx;
      logic [1:0]  port;
      logic [15:0] baud;
      logic [10:0] tx_sh;
      logic [3:0]  tx_n;
      logic [15:0] tx_cnt;
      logic        tx_busy;
      logic        tx1;
      logic        tx2;
      logic        nack_req;
      logic [7:0]  cmd;
      logic        cmd_pend;
      logic [7:0]  rxd;
      logic        rx_avail;
      logic [31:0] addr;
      logic [31:0] count;
      logic        chk_ok;
      logic        dmem_wr;
      logic [1:0]  prot;
      logic [31:0] wd_cnt;
      logic        wd_pulse;
      logic        jump;
      logic        erase_all;
      logic        ack;
      logic [31:0] rdata;
   } state_t;

   function automatic logic cmd_ok(input logic [7:0] c);
      case (c)
         8'h00, 8'h01, 8'h02, 8'h11, 8'h21, 8'h31,
         8'h43, 8'h44, 8'h63, 8'h73, 8'h82, 8'h92: cmd_ok = 1'b1;
         default: cmd_ok = 1'b0;
      endcase
   endfunction : cmd_ok
endpackage : boot_fe_pkg
`default_nettype wire

// *** rtl/boot_fe.sv ***
// serial boot front end: strap capture, port detection, autobaud,
// command screening, address checks, protection levels
// assumes host-side RS-232 transceiver and an Avalon-MM master
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`default_nettype none
module boot_fe
   import boot_fe_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = CLK_HZ / 1_000_000 * REFRESH_US
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // boot straps
   input  wire logic        boot_select_primary_pin,
   input  wire logic        boot_select_secondary_pin,
   // serial ports
   input  wire logic        first_port_receive_input,
   input  wire logic        second_port_receive_input,
   output logic             first_port_transmit_output,
   output logic             second_port_transmit_output,
   // register bus
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // system controls
   output logic             boot_active,
   output logic             sysclk_from_internal_rc,
   output logic [7:0]       sysclk_mhz,
   output logic [1:0]       regulator_range,
   output logic [2:0]       watchdog_prescaler,
   output logic             watchdog_refresh,
   output logic [1:0]       protection_level,
   output logic             flash_mass_erase,
   output logic             app_jump
);

   state_t s;
   state_t next_s;

   function automatic rx_t rx_step(input rx_t r, input logic pin, input logic en,
                                   input logic det);
      rx_t n;
      logic fall;
      logic rise;
      logic good;
      n = r;
      n.got = 1'b0;
      n.sync = {r.sync[1:0], pin};
      // only the agreeing second and third stages move the level
      if (r.sync[1] == r.sync[2]) begin
         n.level = r.sync[2];
      end
      fall = r.level & ~n.level;
      rise = ~r.level & n.level;
      good = 1'b0;
      case (r.phase)
         RX_OFF: begin
            if (en) begin
               n.phase = RX_IDLE;
            end
         end
         RX_IDLE: begin
            if (fall && r.per == 16'h0000) begin
               n.cnt = 16'h0000;
               n.phase = RX_MEAS;
            end else if (fall) begin
               n.cnt = r.per + (r.per >> 1);
               n.bitn = 4'h0;
               n.phase = RX_BITS;
            end
         end
         RX_MEAS: begin
            n.cnt = r.cnt + 16'h0001;
            if (rise) begin
               n.per = n.cnt;
               n.cnt = n.cnt >> 1;
               n.bitn = 4'h0;
               n.phase = RX_BITS;
            end else if (n.cnt == 16'hFFFF) begin
               n.phase = RX_IDLE;
            end
         end
         RX_BITS: begin
            if (r.cnt == 16'h0000) begin
               n.shift = {n.level, r.shift[9:1]};
               n.bitn = r.bitn + 4'h1;
               n.cnt = r.per - 16'h0001;
               if (r.bitn == RX_LAST_BIT) begin
                  n.phase = RX_IDLE;
                  good = n.shift[9] & ~(^n.shift[8:0]);
                  n.got = good;
                  // a wrong first byte restarts the rate search
                  if (det && !(good && n.shift[7:0] == SYNC_BYTE)) begin
                     n.per = 16'h0000;
                  end
               end
            end else begin
               n.cnt = r.cnt - 16'h0001;
            end
         end
         default: n.phase = RX_OFF;
      endcase
      if (!en) begin
         n.phase = RX_OFF;
      end
      return n;
   endfunction : rx_step

   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] e,
                                   input logic [31:0] lo, input logic [31:0] hi);
      return (a >= lo) && (e <= hi) && (e >= a);
   endfunction : in_rng

   // returns {accepted, data memory write}
   function automatic logic [1:0] addr_check(input logic [31:0] a, input logic [31:0] c,
                                             input logic [1:0] k, input logic [1:0] p);
      logic [31:0] e;
      logic fl;
      logic dm;
      logic sr;
      logic ob;
      logic sm;
      logic al;
      logic ok;
      e = a + c - 32'h0000_0001;
      fl = in_rng(a, e, FLASH_BASE, FLASH_LAST);
      dm = in_rng(a, e, DMEM_BASE, DMEM_LAST);
      sr = in_rng(a, e, SRAM_USER, SRAM_LAST);
      ob = in_rng(a, e, OPT_BASE, OPT_LAST);
      sm = in_rng(a, e, SYS_BASE, SYS_LAST);
      al = ((a & ALIGN_MASK) == 32'h0) && ((c & ALIGN_MASK) == 32'h0) && (c != 32'h0);
      case (k)
         KIND_WRITE: ok = al && (fl || dm || sr || ob);
         KIND_ERASE: ok = fl && (c != ERASE_ALL) && (c != 32'h0);
         // read protection hides memory above level 0
         KIND_READ: ok = (p == LEVEL_0) && (c != 32'h0) && (fl || dm || sr || ob || sm);
         default: ok = 1'b0;
      endcase
      return {ok, dm && k == KIND_WRITE};
   endfunction : addr_check

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   logic        req;
   logic        done;
   logic        tx_hold;
   ctrl_t       wc;
   status_t     stat;
   logic [1:0]  chk;
   logic        port_en [2];
   logic        pins [2];
   logic [31:0] rd;

   assign req = avs_read | avs_write;
   assign done = req & s.ack;
   // transmit data waits while a byte is still going out
   assign tx_hold = avs_write && avs_address == REG_TXD && (s.tx_busy || s.nack_req);
   assign avs_waitrequest = req & ~s.ack;
   assign wc = ctrl_t'(avs_writedata);
   assign pins[0] = first_port_receive_input;
   assign pins[1] = second_port_receive_input;
   assign chk = addr_check(s.addr, s.count, wc.kind, s.prot);

   always_comb begin
      stat = '0;
      stat.boot_active = s.st == S_DETECT || s.st == S_CMD;
      stat.dmem_write = s.dmem_wr;
      stat.check_ok = s.chk_ok;
      stat.tx_busy = s.tx_busy | s.nack_req;
      stat.rx_avail = s.rx_avail;
      stat.cmd_pend = s.cmd_pend;
      stat.prot = s.prot;
      stat.st = s.st;
      stat.port = s.port;
      case (avs_address)
         REG_CTRL: rd = {30'h0, s.dmem_wr, s.chk_ok};
         REG_STATUS: rd = 32'(stat);
         REG_BAUD: rd = {16'h0000, s.baud};
         REG_CMD: rd = {24'h000000, s.cmd};
         REG_RXD: rd = {24'h000000, s.rxd};
         REG_ADDR: rd = s.addr;
         REG_COUNT: rd = s.count;
         // half page that the start falls in
         REG_HPAGE: rd = s.addr & HALF_PAGE_MASK;
         default: rd = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.ack = req & ~s.ack & ~tx_hold;
      next_s.jump = 1'b0;
      next_s.erase_all = 1'b0;
      next_s.wd_pulse = 1'b0;
      if (req && !s.ack) begin
         next_s.rdata = rd;
      end
      next_s.sp = {s.sp[1:0], boot_select_primary_pin};
      next_s.ss = {s.ss[1:0], boot_select_secondary_pin};

      if (s.wd_cnt >= 32'(REFRESH_CYC - 1)) begin
         next_s.wd_cnt = 32'h0000_0000;
         next_s.wd_pulse = stat.boot_active;
      end else begin
         next_s.wd_cnt = s.wd_cnt + 32'h0000_0001;
      end

      for (int i = 0; i < 2; i++) begin
         port_en[i] = s.st == S_DETECT || (s.st == S_CMD && s.port == 2'(i + 1));
         next_s.rx[i] = rx_step(s.rx[i], pins[i], port_en[i], s.st == S_DETECT);
      end

      // transmitter, one frame of start, data, parity, stop
      if (s.tx_busy) begin
         if (s.tx_cnt == 16'h0000) begin
            next_s.tx_n = s.tx_n - 4'h1;
            next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
            next_s.tx_cnt = s.baud - 16'h0001;
            next_s.tx_busy = s.tx_n != 4'h1;
         end else begin
            next_s.tx_cnt = s.tx_cnt - 16'h0001;
         end
      end

      // bus writes and read side effects
      if (done && avs_read && avs_address == REG_RXD) begin
         next_s.rx_avail = 1'b0;
      end
      if (done && avs_write) begin
         case (avs_address)
            REG_CTRL: begin
               if (avs_byteenable[0]) begin
                  if (wc.cmd_done) begin
                     next_s.cmd_pend = 1'b0;
                  end
                  if (wc.check) begin
                     next_s.chk_ok = chk[1];
                     next_s.dmem_wr = chk[0];
                     if (!chk[1] && s.st == S_CMD) begin
                        next_s.nack_req = 1'b1;
                     end
                  end
                  if ((wc.prot || wc.unprot) && s.prot == LEVEL_2) begin
                     // level 2 is final
                     next_s.nack_req = s.st == S_CMD;
                  end else if (wc.unprot) begin
                     next_s.erase_all = s.prot == LEVEL_1;
                     next_s.prot = LEVEL_0;
                  end else if (wc.prot) begin
                     next_s.prot = LEVEL_1;
                  end
                  if (wc.go && s.st == S_CMD) begin
                     next_s.st = S_DONE;
                     next_s.jump = 1'b1;
                     next_s.port = PORT_NONE;
                     next_s.baud = 16'h0000;
                     next_s.rx = '0;
                     next_s.cmd_pend = 1'b0;
                     next_s.rx_avail = 1'b0;
                  end
               end
            end
            REG_TXD: begin
               if (avs_byteenable[0] && s.st == S_CMD) begin
                  // even parity on the way out
                  next_s.tx_sh = {1'b1, ^avs_writedata[7:0], avs_writedata[7:0], 1'b0};
                  next_s.tx_n = TX_FRAME_BITS;
                  next_s.tx_cnt = s.baud - 16'h0001;
                  next_s.tx_busy = 1'b1;
               end
            end
            REG_ADDR: next_s.addr = be_merge(s.addr, avs_writedata, avs_byteenable);
            REG_COUNT: next_s.count = be_merge(s.count, avs_writedata, avs_byteenable);
            default: ;
         endcase
      end

      case (s.st)
         S_STRAP: begin
            if (s.wait_n != STRAP_WAIT) begin
               next_s.wait_n = s.wait_n + 2'h1;
            end else if (s.sp[1] == s.sp[2] && s.ss[1] == s.ss[2]) begin
               next_s.st = (s.sp[2] && !s.ss[2]) ? S_DETECT : S_OFF;
            end
         end
         S_DETECT: begin
            // first clean sync wins, first port on a tie
            for (int i = 1; i >= 0; i--) begin
               if (next_s.rx[i].got && next_s.rx[i].shift[7:0] == SYNC_BYTE) begin
                  next_s.port = 2'(i + 1);
                  next_s.baud = next_s.rx[i].per;
                  next_s.st = S_CMD;
               end
            end
         end
         S_CMD: begin
            for (int i = 0; i < 2; i++) begin
               if (port_en[i] && next_s.rx[i].got) begin
                  if (s.cmd_pend) begin
                     next_s.rxd = next_s.rx[i].shift[7:0];
                     next_s.rx_avail = 1'b1;
                  end else if (cmd_ok(next_s.rx[i].shift[7:0])) begin
                     next_s.cmd = next_s.rx[i].shift[7:0];
                     next_s.cmd_pend = 1'b1;
                  end else begin
                     next_s.nack_req = 1'b1;
                  end
               end
            end
         end
         default: ;
      endcase

      // negative answer once the line is free
      if (s.nack_req && !next_s.tx_busy) begin
         next_s.nack_req = 1'b0;
         next_s.tx_sh = {1'b1, ^NACK_BYTE, NACK_BYTE, 1'b0};
         next_s.tx_n = TX_FRAME_BITS;
         next_s.tx_cnt = s.baud - 16'h0001;
         next_s.tx_busy = 1'b1;
      end
      if (next_s.st != S_CMD) begin
         next_s.tx_busy = 1'b0;
         next_s.nack_req = 1'b0;
      end
      // idle high on the port not chosen
      next_s.tx1 = (next_s.port == 2'h1 && next_s.tx_busy) ? next_s.tx_sh[0] : 1'b1;
      next_s.tx2 = (next_s.port == 2'h2 && next_s.tx_busy) ? next_s.tx_sh[0] : 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.st <= S_STRAP;
         s.tx1 <= 1'b1;
         s.tx2 <= 1'b1;
         s.prot <= LEVEL_0;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign first_port_transmit_output = s.tx1;
   assign second_port_transmit_output = s.tx2;
   assign boot_active = stat.boot_active;
   // internal oscillator at 16 MHz while booting
   assign sysclk_from_internal_rc = stat.boot_active;
   assign sysclk_mhz = stat.boot_active ? SYS_CLK_MHZ : 8'h00;
   assign regulator_range = stat.boot_active ? VREG_RANGE : 2'h0;
   assign watchdog_prescaler = stat.boot_active ? WDT_PRESC_MAX : 3'h0;
   assign watchdog_refresh = s.wd_pulse;
   assign protection_level = s.prot;
   assign flash_mass_erase = s.erase_all;
   assign app_jump = s.jump;

endmodule : boot_fe
`default_nettype wire

// *** verif/boot_fe_assertions.sv ***
// checker for the boot front end, watching top-level ports only
// assumes binding onto boot_fe with the same refresh count
`default_nettype none
module boot_fe_assertions
   import boot_fe_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = 50
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // straps and serial
   input wire logic       boot_select_primary_pin,
   input wire logic       boot_select_secondary_pin,
   input wire logic       first_port_transmit_output,
   input wire logic       second_port_transmit_output,
   // system controls
   input wire logic       boot_active,
   input wire logic       sysclk_from_internal_rc,
   input wire logic [7:0] sysclk_mhz,
   input wire logic [1:0] regulator_range,
   input wire logic [2:0] watchdog_prescaler,
   input wire logic       watchdog_refresh,
   input wire logic [1:0] protection_level,
   input wire logic       flash_mass_erase,
   input wire logic       app_jump
);
   logic [15:0] gap;
   // cycles since last refresh; a counter keeps the long span cheap
   always_ff @(posedge clk) begin
      if (rst || watchdog_refresh || !boot_active) gap <= 16'h0000;
      else gap <= gap + 16'h0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_clock_internal: assert property (boot_active |-> sysclk_from_internal_rc && sysclk_mhz == 8'h10)
      else $error("system clock wrong in boot");
   a_regulator_two: assert property (boot_active |-> regulator_range == 2'h2)
      else $error("regulator range wrong in boot");
   a_watchdog_max: assert property (boot_active |-> watchdog_prescaler == 3'h7)
      else $error("watchdog prescaler not at maximum");
   a_refresh_gap: assert property (gap <= REFRESH_CYC)
      else $error("watchdog refresh overdue");
   a_boot_straps: assert property ($rose(boot_active) |-> boot_select_primary_pin && !boot_select_secondary_pin)
      else $error("boot entered with wrong straps");
   a_port_exclusive: assert property (first_port_transmit_output || second_port_transmit_output)
      else $error("both ports transmitting");
   a_level_legal: assert property (protection_level <= 2'h2)
      else $error("protection level out of range");
   a_erase_cause: assert property (flash_mass_erase |-> $past(protection_level) == 2'h1 ##1 !flash_mass_erase)
      else $error("flash erase without level one to zero");
   a_jump_exit: assert property (app_jump |=> !app_jump && !boot_active && watchdog_prescaler == 3'h0)
      else $error("jump left boot settings in place");
endmodule : boot_fe_assertions
bind boot_fe boot_fe_assertions #(.REFRESH_CYC(REFRESH_CYC)) u_chk (.clk, .rst,
   .boot_select_primary_pin, .boot_select_secondary_pin, .first_port_transmit_output,
   .second_port_transmit_output, .boot_active, .sysclk_from_internal_rc, .sysclk_mhz,
   .regulator_range, .watchdog_prescaler, .watchdog_refresh, .protection_level,
   .flash_mass_erase, .app_jump);
`default_nettype wire

// *** verif/host_serial_model.sv ***
// host side serial model: sends framed bytes, decodes replies
// assumes tasks are called right after a rising clock edge
`default_nettype none
module host_serial_model #(
   parameter int BIT = 16
) (
   input  wire logic clk,
   input  wire logic from_dev,
   output var  logic to_dev
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle line held high, never floating
   initial to_dev = 1'b1;
   // start, lsb first, even parity, stop; bad flips parity
   task automatic send(input logic [7:0] d, input logic bad);
      logic [10:0] f;
      f = {1'b1, ^d ^ bad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         to_dev <= f[i];
         repeat (BIT - 1) @(posedge clk);
      end
   endtask : send
   task automatic get(output logic [7:0] d, output logic ok);
      logic [9:0] f;
      int n = 0;
      while (from_dev !== 1'b0 && n < 40 * BIT) begin
         @(posedge clk);
         n++;
      end
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT) @(posedge clk);
         f[i] = from_dev;
      end
      d = f[7:0];
      ok = (n < 40 * BIT) && (^f[8:0] == 1'b0) && (f[9] === 1'b1);
   endtask : get
endmodule : host_serial_model
`default_nettype wire

// *** verif/serial_boot_interface_front_end_bench.sv ***
// bench for the boot front end: register bus tasks and two hosts
// assumes package, design, checker and host model compiled first
`default_nettype none
module serial_boot_interface_front_end_bench
   import boot_fe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ok;
   logic boot_select_primary_pin = 1'b0, boot_select_secondary_pin = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, q;
   wire logic first_port_receive_input, second_port_receive_input, avs_waitrequest;
   wire logic first_port_transmit_output, second_port_transmit_output;
   wire logic boot_active, flash_mass_erase, app_jump;
   wire logic [1:0] regulator_range, protection_level;
   wire logic [31:0] avs_readdata;
   logic [7:0] erase_seen = 8'h00, jump_seen = 8'h00, rxb;
   int fail_count = 0, samples_checked = 0;
   logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h11, 8'h21, 8'h31,
                              8'h43, 8'h44, 8'h63, 8'h73, 8'h82, 8'h92};
   logic [31:0] ca [10] = '{FLASH_BASE, 32'h0800_0002, FLASH_BASE, DMEM_BASE, 32'h0808_0FFC,
                            DMEM_BASE, SRAM_BASE, OPT_BASE, FLASH_BASE, FLASH_BASE};
   logic [31:0] cc [10] = '{32'h100, 32'h4, 32'h6, 32'h4, 32'h8, 32'h4, 32'h4, 32'h4,
                            ERASE_ALL, 32'h80};
   logic [1:0] ck [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1};
   logic ce [10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (flash_mass_erase === 1'b1) erase_seen <= erase_seen + 8'h01;
      if (app_jump === 1'b1) jump_seen <= jump_seen + 8'h01;
   end
   boot_fe #(.REFRESH_CYC(50)) u_dut (.clk, .rst, .boot_select_primary_pin,
      .boot_select_secondary_pin, .first_port_receive_input, .second_port_receive_input,
      .first_port_transmit_output, .second_port_transmit_output, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .boot_active, .sysclk_from_internal_rc(), .sysclk_mhz(), .regulator_range,
      .watchdog_prescaler(), .watchdog_refresh(), .protection_level, .flash_mass_erase,
      .app_jump);
   host_serial_model u_h1 (.clk, .from_dev(first_port_transmit_output),
                           .to_dev(first_port_receive_input));
   host_serial_model u_h2 (.clk, .from_dev(second_port_transmit_output),
                           .to_dev(second_port_receive_input));
   task automatic complete_run;
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // request held until waitrequest is sampled low at a rising edge, released at that edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 200);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 200) begin
         fail_count++;
         complete_run();
      end
   endtask : bus
   task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(what, q & m, e);
   endtask : rd_chk
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (20) @(posedge clk);
      rd_chk("state off", REG_STATUS, 32'h101C, 32'h4);
      rst <= 1'b1;
      boot_select_primary_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (20) @(posedge clk);
      rd_chk("state detect", REG_STATUS, 32'h101F, 32'h1008);
      check("regulator", regulator_range, 2'h2);
      u_h1.send(SYNC_BYTE, 1'b1);
      rd_chk("no port", REG_STATUS, 32'h1F, 32'h8);
      u_h2.send(SYNC_BYTE, 1'b0);
      repeat (8) @(posedge clk);
      rd_chk("port second", REG_STATUS, 32'h1F, 32'hE);
      rd_chk("bit period", REG_BAUD, 32'hFFFF, 32'h10);
      u_h1.send(8'h11, 1'b0);
      repeat (8) @(posedge clk);
      rd_chk("other port off", REG_STATUS, 32'h80, 32'h0);
      foreach (codes[i]) begin
         u_h2.send(codes[i], 1'b0);
         repeat (8) @(posedge clk);
         rd_chk("command", REG_CMD, 32'hFF, {24'h0, codes[i]});
         bus(1'b1, REG_CTRL, 32'h8);
      end
      fork
         u_h2.send(8'h05, 1'b0);
         u_h2.get(rxb, ok);
      join
      check("reject byte", {ok, rxb}, {1'b1, NACK_BYTE});
      u_h2.send(8'h11, 1'b0);
      u_h2.send(8'h3C, 1'b0);
      rd_chk("data byte", REG_RXD, 32'hFF, 32'h3C);
      bus(1'b1, REG_TXD, 32'hC3);
      u_h2.get(rxb, ok);
      check("sent byte", {ok, rxb}, {1'b1, 8'hC3});
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, REG_ADDR, ca[i]);
         bus(1'b1, REG_COUNT, cc[i]);
         bus(1'b1, REG_CTRL, {25'h0, ck[i], 5'h10});
         rd_chk("range check", REG_CTRL, 32'h1, {31'h0, ce[i]});
      end
      bus(1'b1, REG_ADDR, 32'h0800_00C4);
      rd_chk("half page", REG_HPAGE, 32'hFFFF_FFFF, 32'h0800_0080);
      bus(1'b1, REG_CTRL, 32'h2);
      @(negedge clk);
      check("level one", protection_level, 2'h1);
      bus(1'b1, REG_CTRL, 32'h4);
      repeat (2) @(negedge clk);
      check("level zero", protection_level, 2'h0);
      check("flash erase", erase_seen, 8'h01);
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (2) @(negedge clk);
      check("jump", {jump_seen, boot_active}, {8'h01, 1'b0});
      complete_run();
   end
endmodule : serial_boot_interface_front_end_bench
`default_nettype wire
